// ==== design/lfst_consts.svh ====
`ifndef LFST_CONSTS_SVH
`define LFST_CONSTS_SVH

// Serial command code of the status word
`define LFST_CMD_STATUS 8'h12

// Status word field positions
`define LFST_BIT_TX_READY 10
`define LFST_BIT_TX_ENABLED 9
`define LFST_BIT_EN_PIN 8
`define LFST_BIT_TWICE 7
`define LFST_BIT_ONCE 6
`define LFST_BIT_FAULTED 5
`define LFST_BIT_UNDER_VOLT 4
`define LFST_BIT_LOAD_ERR 3
`define LFST_BIT_OVER_PWR 2
`define LFST_BIT_UNDER_PWR 1
`define LFST_BIT_OVER_CUR 0
`define LFST_LATCH_HI 4
`define LFST_LATCH_LO 0

// Power-on values of the state bits
`define LFST_RST_TX_READY 1'h0
`define LFST_RST_TWICE 1'h0
`define LFST_RST_ONCE 1'h1
`define LFST_RST_FAULTED 1'h1
`define LFST_RST_LATCHED 5'h10

// Repeat-fault window
`define LFST_WINDOW_MS 25
`define LFST_CLK_HZ 20000000
`define LFST_MS_PER_S 1000

`endif

// ==== design/lfst_pkg.sv ====
package lfst_pkg;

  // Five clear-on-read fault indicators, in status word order
  typedef struct packed {
    logic underVolt;
    logic loadErr;
    logic overPwr;
    logic underPwr;
    logic overCur;
  } lfst_latched_t;

  // Configuration levels from the device's configuration register
  typedef struct packed {
    logic softEn;
    logic enActiveHigh;
    logic repFltInhibit;
    logic autoShutdnEn;
    logic overPwrEn;
    logic underPwrEn;
    logic overCurrentEn;
    logic closedLoopPowerMode;
  } lfst_config_t;

  // Condition inputs from the analog monitors and the loader
  typedef struct packed {
    logic currentsSettled;
    logic monitorAboveSetPoint;
    logic monitorBelowSetPoint;
    logic memLoadStart;
    logic memLoadDone;
    logic memLoadOk;
  } lfst_sense_t;

endpackage

// ==== design/laser_fault_status_tracker.sv ====
`timescale 1ns/1ps
`include "lfst_consts.svh"

// How it works
// - Ready bit set when settled, cleared by fault
// - Enabled bit needs pin, soft enable, no fault
// - Bit 8 shows raw enable pin level
// - Pin bit follows real pin from reset
// - Once/twice flags only with repeat inhibit set
// - Once flag set when faulted transmitter disabled
// - Fault within 25ms of re-enable sets twice
// - Quiet 25ms after re-enable clears once
// - Twice flag locks transmitter off until power cycle
// - Any fault sets faulted bit, no shutdown alone
// - Undervoltage always latched, set at power-up
// - Status read clears only bits 4..0
// - Started load that ends without ok latches load error
// - Overpower latched if enabled and closed loop
// - Underpower latched if enabled and closed loop
// - Overcurrent latched if enabled and bias exceeds limit
// - Auto shutdown disables transmitter on fault
module laser_fault_status_tracker #(
  parameter int WINDOW_CYCLES =
    `LFST_WINDOW_MS * (`LFST_CLK_HZ / `LFST_MS_PER_S),
  parameter int LIMIT_WIDTH = 7
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enPin,
  input wire logic underVoltPin,
  input wire lfst_pkg::lfst_config_t cfg,
  input wire lfst_pkg::lfst_sense_t sense,
  input wire logic [LIMIT_WIDTH-1:0] biasCurrent,
  input wire logic [LIMIT_WIDTH-1:0] biasLimitRegister,
  input wire logic [7:0] cmdCode,
  input wire logic rdStrobe,
  output logic [15:0] rdData,
  output logic rdValid,
  output logic [15:0] statusWord,
  output logic txEnable,
  output logic faultActive
);
  import lfst_pkg::*;

  localparam int TW = $clog2(WINDOW_CYCLES + 1);
  localparam logic [TW-1:0] WINDOW_LAST = TW'(WINDOW_CYCLES - 1);
  localparam int LATCH_W = $bits(lfst_latched_t);
  localparam logic [LATCH_W-1:0] LATCH_RESET = `LFST_RST_LATCHED;

  typedef struct packed {
    logic txReady;
    logic twice;
    logic once;
    logic faulted;
    logic prevUserEn;
    logic windowOn;
    logic [TW-1:0] windowCnt;
    logic loadBusy;
    logic [15:0] rdData;
    logic rdValid;
  } lfst_state_t;

  lfst_state_t r;
  lfst_state_t next_r;

  logic enLevel;
  logic uvLevel;
  logic pinActive;
  logic userEn;
  logic userRise;
  logic userFall;
  logic statusRead;
  logic apcOk;
  logic biasOver;
  logic overPwrGate;
  logic underPwrGate;
  logic overCurGate;
  logic loadFail;
  logic userClear;
  logic windowStart;
  logic windowAbort;
  logic windowExpire;
  logic repeatFault;
  logic shutdownHold;
  logic settledOk;
  wire logic [LATCH_W-1:0] latchedBits;
  lfst_latched_t events;
  logic newFault;
  logic txOn;
  logic [15:0] word;

  // No reset on the synchronisers: bit 8 shows the pin from power-on
  lfst_sync2 u_en_sync (
    .clk(clk),
    .pinIn(enPin),
    .pinOut(enLevel)
  );
  lfst_sync2 u_uv_sync (
    .clk(clk),
    .pinIn(underVoltPin),
    .pinOut(uvLevel)
  );

  // Bit 8 stays raw; polarity only shapes the user enable
  assign pinActive = (enLevel == cfg.enActiveHigh);
  assign userEn = pinActive && cfg.softEn;
  assign userRise = !r.prevUserEn && userEn;
  assign userFall = r.prevUserEn && !userEn;
  assign statusRead = rdStrobe && (cmdCode == `LFST_CMD_STATUS);
  assign apcOk = cfg.closedLoopPowerMode;

  // Power faults only mean something in closed loop
  assign biasOver = (biasCurrent > biasLimitRegister);
  assign overPwrGate = cfg.overPwrEn && apcOk;
  assign underPwrGate = cfg.underPwrEn && apcOk;
  assign overCurGate = cfg.overCurrentEn;
  assign loadFail = r.loadBusy && sense.memLoadDone && !sense.memLoadOk;

  // Fault sources seen this cycle
  always_comb begin
    events = '0;
    events.underVolt = uvLevel;
    events.loadErr = loadFail;
    events.overPwr = overPwrGate && sense.monitorAboveSetPoint;
    events.underPwr = underPwrGate && sense.monitorBelowSetPoint;
    events.overCur = overCurGate && biasOver;
  end

  assign newFault = |events;
  assign userClear = userFall && r.faulted;
  assign windowStart = userRise && r.once && !r.twice;
  assign windowAbort = r.windowOn && !userEn;
  assign windowExpire = r.windowOn && (r.windowCnt == WINDOW_LAST);
  assign repeatFault = r.windowOn && newFault && cfg.repFltInhibit;
  assign shutdownHold = r.faulted && cfg.autoShutdnEn;
  assign settledOk = sense.currentsSettled && !newFault;

  // One latch per indicator; a fault in the read cycle beats the clear
  for (genvar i = 0; i < LATCH_W; i++) begin : g_latch
    lfst_latch_bit #(
      .RESET_VALUE(LATCH_RESET[i])
    ) u_bit (
      .clk(clk),
      .rst(rst),
      .setEvent(events[i]),
      .clearRead(statusRead),
      .flag(latchedBits[i])
    );
  end

  // Laser keeps running through a fault unless auto shutdown is on or a repeat fault set twice
  assign txOn = userEn
                && !r.twice
                && !shutdownHold;

  always_comb begin
    word = '0;
    word[`LFST_BIT_TX_READY] = r.txReady;
    word[`LFST_BIT_TX_ENABLED] = txOn && !r.faulted;
    word[`LFST_BIT_EN_PIN] = enLevel;
    word[`LFST_BIT_TWICE] = r.twice && cfg.repFltInhibit;
    word[`LFST_BIT_ONCE] = r.once && cfg.repFltInhibit;
    word[`LFST_BIT_FAULTED] = r.faulted;
    word[`LFST_LATCH_HI:`LFST_LATCH_LO] = latchedBits;
  end

  always_comb begin
    next_r = r;
    next_r.prevUserEn = userEn;
    next_r.rdValid = statusRead;
    if (statusRead) begin
      next_r.rdData = word;
    end

    // A done without a start is no load error
    if (sense.memLoadStart) begin
      next_r.loadBusy = 1'b1;
    end else if (sense.memLoadDone) begin
      next_r.loadBusy = 1'b0;
    end

    next_r.txReady = txOn && !r.faulted && settledOk;

    // Disabling the transmitter is the attempt to clear a fault
    if (userClear) begin
      next_r.faulted = 1'b0;
      if (cfg.repFltInhibit) begin
        next_r.once = 1'b1;
      end
    end
    if (newFault) begin
      next_r.faulted = 1'b1;
    end

    // Window opens on re-enable; dropping the enable again aborts it
    if (windowStart) begin
      next_r.windowOn = 1'b1;
      next_r.windowCnt = '0;
    end else if (repeatFault) begin
      next_r.twice = 1'b1;
      next_r.windowOn = 1'b0;
    end else if (windowAbort) begin
      next_r.windowOn = 1'b0;
    end else if (windowExpire) begin
      next_r.once = 1'b0;
      next_r.windowOn = 1'b0;
    end else if (r.windowOn) begin
      next_r.windowCnt = r.windowCnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
      r.txReady <= `LFST_RST_TX_READY;
      r.twice <= `LFST_RST_TWICE;
      r.once <= `LFST_RST_ONCE;
      r.faulted <= `LFST_RST_FAULTED;
      // History follows the enable, so release makes no false edge
      r.prevUserEn <= next_r.prevUserEn;
    end else begin
      r <= next_r;
    end
  end

  assign rdData = r.rdData;
  assign rdValid = r.rdValid;
  assign statusWord = word;
  assign txEnable = txOn;
  assign faultActive = r.faulted;
endmodule // laser_fault_status_tracker

// Pin synchroniser; runs free so the level is known at reset release
module lfst_sync2 #(
  parameter int STAGES = 2
) (
  input wire logic clk,
  input wire logic pinIn,
  output logic pinOut
);
  import lfst_pkg::*;

  typedef struct packed {
    logic [STAGES-1:0] stage;
  } lfst_sync_state_t;

  lfst_sync_state_t r;
  lfst_sync_state_t next_r;

  // Only the last stage is read; the first may be metastable
  always_comb begin
    next_r = r;
    next_r.stage = {r.stage[STAGES-2:0], pinIn};
  end

  always_ff @(posedge clk) begin
    r <= next_r;
  end

  assign pinOut = r.stage[STAGES-1];
endmodule // lfst_sync2

// Clear-on-read indicator; a set in the read cycle wins over the clear
module lfst_latch_bit #(
  parameter logic RESET_VALUE = 1'h0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic setEvent,
  input wire logic clearRead,
  output logic flag
);
  import lfst_pkg::*;

  typedef struct packed {
    logic flag;
  } lfst_latch_state_t;

  lfst_latch_state_t r;
  lfst_latch_state_t next_r;

  always_comb begin
    next_r = r;
    if (clearRead) begin
      next_r.flag = 1'h0;
    end
    if (setEvent) begin
      next_r.flag = 1'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r.flag <= RESET_VALUE;
    end else begin
      r <= next_r;
    end
  end

  assign flag = r.flag;
endmodule // lfst_latch_bit

// ==== dv/lfst_host.sv ====
`timescale 1ns/1ps
module lfst_host (
  input wire logic clk,
  input wire logic rdValid,
  input wire logic [15:0] rdData,
  output logic rdStrobe,
  output logic [7:0] cmdCode
);
  initial begin
    rdStrobe = 1'h0;
    cmdCode = 8'h00;
  end
  // Returns {answered, data}; code inverted once released
  task automatic rd(input logic [7:0] c, output logic [16:0] d);
    @(posedge clk) #1;
    rdStrobe = 1'h1;
    cmdCode = c;
    @(posedge clk) #1;
    rdStrobe = 1'h0;
    cmdCode = ~c;
    d = {rdValid, rdData};
  endtask
endmodule // lfst_host

// ==== dv/lfst_asserts.sv ====
`timescale 1ns/1ps
module lfst_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire lfst_pkg::lfst_config_t cfg,
  input wire logic [6:0] biasCurrent,
  input wire logic [6:0] biasLimitRegister,
  input wire logic [7:0] cmdCode,
  input wire logic rdStrobe,
  input wire logic [15:0] rdData,
  input wire logic rdValid,
  input wire logic [15:0] statusWord,
  input wire logic txEnable,
  input wire logic faultActive
);
  import lfst_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence rd_req;
    rdStrobe && cmdCode == 8'h12;
  endsequence
  a_rd_answer: assert property (rd_req |=> rdValid &&
    rdData == $past(statusWord)) else $error("read answer wrong");
  a_rd_refused: assert property (rdStrobe && cmdCode != 8'h12
    |=> !rdValid) else $error("foreign code answered");
  a_rsvd_zero: assert property (statusWord[15:11] == 5'h00)
    else $error("reserved bits set");
  a_oc_latch: assert property (cfg.overCurrentEn &&
    biasCurrent > biasLimitRegister |=> statusWord[0] && faultActive)
    else $error("overcurrent missed");
  a_tx_state: assert property (statusWord[9] ==
    (txEnable && !faultActive)) else $error("enabled bit wrong");
  a_ready_clear: assert property (faultActive |->
    !statusWord[10]) else $error("ready while faulted");
  a_auto_off: assert property (cfg.autoShutdnEn && faultActive
    |-> !txEnable) else $error("no auto shutdown");
  a_once_gate: assert property (!cfg.repFltInhibit |->
    statusWord[7:6] == 2'h0) else $error("flags not gated");
  a_twice_lock: assert property (statusWord[7] |-> !txEnable)
    else $error("drive after repeat");
endmodule // lfst_asserts
bind laser_fault_status_tracker lfst_asserts u_chk (.clk(clk), .rst(rst),
  .cfg(cfg), .biasCurrent(biasCurrent),
  .biasLimitRegister(biasLimitRegister), .cmdCode(cmdCode),
  .rdStrobe(rdStrobe), .rdData(rdData), .rdValid(rdValid),
  .statusWord(statusWord), .txEnable(txEnable), .faultActive(faultActive));

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import lfst_pkg::*;
  logic clk, rst, enPin, uvPin, rdStrobe, rdValid, txEnable, faultActive;
  lfst_config_t cfg;
  lfst_sense_t sense;
  logic [6:0] bias, lim;
  logic [7:0] cmdCode;
  logic [15:0] rdData, statusWord;
  logic [16:0] r;
  int fail_count, comparisons;
  laser_fault_status_tracker #(.WINDOW_CYCLES(50)) DUT (.clk(clk),
    .rst(rst), .enPin(enPin), .underVoltPin(uvPin), .cfg(cfg),
    .sense(sense), .biasCurrent(bias), .biasLimitRegister(lim),
    .cmdCode(cmdCode), .rdStrobe(rdStrobe), .rdData(rdData),
    .rdValid(rdValid), .statusWord(statusWord), .txEnable(txEnable),
    .faultActive(faultActive));
  lfst_host host (.clk(clk), .rdValid(rdValid), .rdData(rdData),
    .rdStrobe(rdStrobe), .cmdCode(cmdCode));
  task automatic chk(logic [16:0] g, logic [16:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk) #1;
  endtask
  task automatic t_boot();
    host.rd(8'h12, r);
    chk(r, 17'h10170);
    cfg.repFltInhibit = 1'h0;
    cyc(1);
    chk(statusWord[7:6], 2'h0);
    cfg.repFltInhibit = 1'h1;
    host.rd(8'h12, r);
    chk(r, 17'h10160);
    host.rd(8'h11, r);
    chk(r[16], 1'h0);
    $display("boot done");
  endtask
  task automatic t_quiet();
    cfg.softEn = 1'h0;
    cyc(2);
    chk(statusWord[6:5], 2'h2);
    cfg.softEn = 1'h1;
    sense = 6'h20;
    cyc(60);
    chk(statusWord, 16'h0700);
    $display("quiet done");
  endtask
  task automatic t_fault();
    bias = 7'h7e;
    cyc(2);
    chk(statusWord[5], 1'h0);
    bias = 7'h7f;
    cyc(1);
    bias = 7'h00;
    chk({txEnable, statusWord}, 17'h00121);
    cfg.softEn = 1'h0;
    cyc(2);
    cfg.softEn = 1'h1;
    cyc(5);
    chk(txEnable, 1'h1);
    bias = 7'h7f;
    cyc(1);
    bias = 7'h00;
    chk({txEnable, statusWord[7]}, 2'h1);
    enPin = 1'h0;
    cfg.softEn = 1'h0;
    cyc(3);
    chk(statusWord[8], 1'h0);
    enPin = 1'h1;
    cfg.softEn = 1'h1;
    cyc(4);
    chk(txEnable, 1'h0);
    $display("fault done");
  endtask
  task automatic t_latch();
    host.rd(8'h12, r);
    chk(statusWord[8:0], 9'h1c0);
    cfg.closedLoopPowerMode = 1'h0;
    sense = 6'h38;
    cyc(1);
    sense = 6'h20;
    cyc(1);
    chk(statusWord[2:1], 2'h0);
    cfg.closedLoopPowerMode = 1'h1;
    sense = 6'h38;
    cyc(1);
    sense = 6'h24;
    chk(statusWord[2:1], 2'h3);
    cyc(1);
    sense = 6'h22;
    uvPin = 1'h1;
    cyc(1);
    sense = 6'h20;
    uvPin = 1'h0;
    cyc(3);
    chk(statusWord[4:3], 2'h3);
    cfg.enActiveHigh = 1'h0;
    cyc(1);
    chk(statusWord[8], 1'h1);
    $display("latch done");
  endtask
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  initial begin
    rst = 1'h1;
    enPin = 1'h1;
    uvPin = 1'h0;
    cfg = 8'hfe;
    sense = 6'h00;
    bias = 7'h00;
    lim = 7'h7e;
    fail_count = 0;
    comparisons = 0;
    repeat (16) @(posedge clk);
    #1 rst = 1'h0;
    t_boot();
    t_quiet();
    t_fault();
    t_latch();
    final_report();
  end
  // Tests take about 115 cycles
  initial begin
    #100000;
    fail_count++;
    final_report();
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
endmodule // tb_top
